// *** hdl/cpu_alu_datapath.sv ***
// CPU arithmetic datapath: ALU, status flags, 17x17 multiplier, divider
// control and the sixteen-entry working register file behind AHB-Lite.
// Assumes one AHB-Lite master doing single word transfers.
`timescale 1ns/1ps
module cpu_alu_datapath
	import alu_dp_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              arst_n,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// Core view
	output logic [15:0]            stackPointer
);
	localparam int NUM_W = 16;

	// The map needs offsets up to 0x7c
	if (ADDR_W < 7) begin : g_chk
		$error("ADDR_W too small for the register map");
	end

	// Bus slave state
	logic              pend_reg;    // Data phase outstanding
	logic [ADDR_W-1:0] addr_reg;    // Captured address
	logic              isWrite_reg; // Captured direction
	logic              ready_reg;   // Drives hreadyout
	logic              resp_reg;    // Always OKAY
	logic [31:0]       rdata_reg;   // Read data
	// Software-visible registers
	logic [31:0]       ctrl_reg;           // Last control word
	logic [15:0]       memIn_reg;          // Memory-side operand
	logic [15:0]       memOut_reg;         // Memory-side result
	logic [15:0]       statusFlags_reg;    // Status flags word
	logic [15:0]       statusFlags_next;
	logic [15:0]       wfile_reg [NUM_W];  // Working registers

	div_if dv ();

	// Divider unit
	alu_divider u_div (
		.mclk   (mclk),
		.arst_n (arst_n),
		.dv     (dv.unit)
	);

	// Address phase accept and data phase execute
	wire accept  = hsel & htrans[1] & hready;
	// Any access waits while a divide runs, so its write-back never collides
	wire doAcc   = pend_reg & ~dv.busy;
	wire busWr   = doAcc & isWrite_reg;
	wire busRd   = doAcc & ~isWrite_reg;
	wire aligned = addr_reg[1:0] == 2'b00;

	// Register decode
	wire hitCtrl   = addr_reg == ADDR_W'(OFS_CTRL);
	wire hitMemIn  = addr_reg == ADDR_W'(OFS_MEM_IN);
	wire hitMemOut = addr_reg == ADDR_W'(OFS_MEM_OUT);
	wire hitFlags  = addr_reg == ADDR_W'(OFS_STATUS_FLAGS_WORD);
	wire hitWfile  = (addr_reg[ADDR_W-1:6] == (ADDR_W-6)'(OFS_WFILE >> 6)) & aligned;
	wire [3:0] wIdx = addr_reg[5:2];

	// Control word fields, taken from the write data in the execute cycle
	wire       ctrlWr = busWr & hitCtrl;
	op_e       op;
	assign op = op_e'(hwdata[CTL_OP+3:CTL_OP]);
	wire       byteMd = hwdata[CTL_BYTE];
	wire       srcMem = hwdata[CTL_SRC_MEM];
	wire       dstMem = hwdata[CTL_DST_MEM];
	wire       isLong = hwdata[CTL_LONG];
	wire [3:0] raIdx  = hwdata[CTL_RA+3:CTL_RA];
	wire [3:0] rbIdx  = hwdata[CTL_RB+3:CTL_RB];
	wire [3:0] rdIdx  = hwdata[CTL_RD+3:CTL_RD];
	wire [4:0] litVal = hwdata[CTL_LIT+4:CTL_LIT];

	// Operation classes
	wire isSub   = op == ALU_SUB;
	wire isArith = (op == ALU_ADD) | isSub;
	wire isLogic = (op == ALU_AND) | (op == ALU_IOR) | (op == ALU_XOR);
	wire isShift = (op == ALU_SHL) | (op == ALU_LSR) | (op == ALU_ASR);
	wire isDiv   = (op == DIV_S) | (op == DIV_U);
	wire isMul   = op[3] & ~isDiv;
	wire isLit   = (op == MUL_SLIT) | (op == MUL_ULIT);
	wire exeAlu  = ctrlWr & ~isDiv;

	// Operand fetch
	wire [15:0] aOp = wfile_reg[raIdx];
	wire [15:0] bOp = srcMem ? memIn_reg : wfile_reg[rbIdx];
	// Width masking, byte operands zero-extended
	wire [15:0] aM  = byteMd ? {8'h00, aOp[7:0]} : aOp;
	wire [15:0] bM  = byteMd ? {8'h00, bOp[7:0]} : bOp;

	// Adder: subtract adds the inverted operand plus one
	wire [15:0] bE  = isSub ? (byteMd ? {8'h00, ~bM[7:0]} : ~bM) : bM;
	wire [16:0] sum17 = {1'b0, aM} + {1'b0, bE} + {16'h0000, isSub};
	wire [4:0]  nib5  = {1'b0, aM[3:0]} + {1'b0, bE[3:0]} + {4'h0, isSub};
	wire [8:0]  nib9  = {1'b0, aM[7:0]} + {1'b0, bE[7:0]} + {8'h00, isSub};

	// Shifter, amount from the second operand
	wire [3:0]  shamt = bOp[3:0];
	wire [15:0] aS    = byteMd ? {{8{aOp[7]}}, aOp[7:0]} : aOp;
	wire [16:0] shl17 = {1'b0, aM} << shamt;
	wire [16:0] lsr17 = {aM, 1'b0} >> shamt;
	wire [16:0] asr17 = $unsigned($signed({aS, 1'b0}) >>> shamt);

	// Multiplier: sign extension to 17 bits selects the mode
	wire aSgn = (op == MUL_SS) | (op == MUL_SU) | (op == MUL_SLIT);
	wire bSgn = (op == MUL_SS) | (op == MUL_US);
	// Literal modes use the 5-bit field as unsigned
	wire [15:0] aMul = byteMd ? aM : aOp;
	wire [15:0] bMul = isLit ? {11'h000, litVal} : (byteMd ? bM : bOp);
	wire [16:0] mulA = {aSgn & aMul[15], aMul};
	wire [16:0] mulB = {bSgn & bMul[15] & ~isLit, bMul};
	logic signed [33:0] mulP;
	assign mulP = $signed(mulA) * $signed(mulB);
	// Unsigned byte by byte gives one word
	wire mulWide = isMul & ~(byteMd & (op == MUL_UU));

	// Result select
	logic [15:0] aluRes;
	logic        shC;
	always_comb begin
		aluRes = 16'h0000;
		shC    = statusFlags_reg[POS_CARRY];
		unique case (op)
			ALU_ADD, ALU_SUB: aluRes = sum17[15:0];
			ALU_AND: aluRes = aM & bM;
			ALU_IOR: aluRes = aM | bM;
			ALU_XOR: aluRes = aM ^ bM;
			// Carry takes the last bit shifted out
			ALU_SHL: begin
				aluRes = shl17[15:0];
				shC    = byteMd ? shl17[8] : shl17[16];
			end
			ALU_LSR: begin
				aluRes = lsr17[16:1];
				shC    = lsr17[0];
			end
			ALU_ASR: begin
				aluRes = asr17[16:1];
				shC    = asr17[0];
			end
			MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SLIT, MUL_ULIT: aluRes = mulP[15:0];
			DIV_S, DIV_U: aluRes = 16'h0000;
		endcase
	end

	// Flag terms from the selected width
	wire resZero = byteMd ? (aluRes[7:0] == 8'h00) : (aluRes == 16'h0000);
	wire resNeg  = byteMd ? aluRes[7] : aluRes[15];
	wire carryA  = byteMd ? sum17[8] : sum17[16];
	wire nibC    = byteMd ? nib5[4] : nib9[8];
	wire signA   = byteMd ? aM[7] : aM[15];
	wire signB   = byteMd ? bE[7] : bE[15];
	wire rangeX  = (signA == signB) & (resNeg != signA);

	// Flag update; subtract leaves carry set when nothing was borrowed
	always_comb begin
		statusFlags_next = statusFlags_reg;
		if (exeAlu && (isArith || isLogic || isShift)) begin
			statusFlags_next[POS_ZERO] = resZero;
			statusFlags_next[POS_NEG]  = resNeg;
		end
		if (exeAlu && isArith) begin
			statusFlags_next[POS_CARRY]  = carryA;
			statusFlags_next[POS_NIBBLE] = nibC;
			statusFlags_next[POS_RANGE]  = rangeX;
		end
		// A zero shift keeps the old carry
		if (exeAlu && isShift && (shamt != 4'h0)) begin
			statusFlags_next[POS_CARRY] = shC;
		end
	end

	// Write-back: byte results other than products keep the destination's upper byte
	wire [15:0] dstOld   = dstMem ? memOut_reg : wfile_reg[rdIdx];
	wire [15:0] loVal    = isMul ? mulP[15:0] :
		(byteMd ? {dstOld[15:8], aluRes[7:0]} : aluRes);
	// Wide products land in the even/odd pair holding the destination
	wire [3:0]  loIdx    = mulWide ? {rdIdx[3:1], 1'b0} : rdIdx;
	wire [3:0]  hiIdx    = {rdIdx[3:1], 1'b1};
	wire        aluWe    = exeAlu & ~dstMem;

	// Divider launch; the long form reads the aligned pair
	wire [3:0]  pairLo   = {raIdx[3:1], 1'b0};
	wire [3:0]  pairHi   = {raIdx[3:1], 1'b1};
	wire [15:0] shortDvd = wfile_reg[raIdx];
	wire [15:0] shortExt = (op == DIV_S) ? {16{shortDvd[15]}} : 16'h0000;
	assign dv.start    = ctrlWr & isDiv;
	assign dv.isSigned = op == DIV_S;
	assign dv.dividend = isLong ? {wfile_reg[pairHi], wfile_reg[pairLo]} :
		{shortExt, shortDvd};
	// Any working register may hold the divisor
	assign dv.divisor  = wfile_reg[rbIdx];

	// Working register file, one flop word per entry
	for (genvar i = 0; i < NUM_W; i++) begin : g_wfile
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				wfile_reg[i] <= WFILE_RST;
			end else if (dv.done && (4'(i) == QUOT_IDX)) begin
				wfile_reg[i] <= dv.quotient;
			end else if (dv.done && (4'(i) == REM_IDX)) begin
				wfile_reg[i] <= dv.remainder;
			end else if (busWr && hitWfile && (wIdx == 4'(i))) begin
				wfile_reg[i] <= hwdata[15:0];
			end else if (aluWe && (loIdx == 4'(i))) begin
				wfile_reg[i] <= loVal;
			end else if (aluWe && mulWide && (hiIdx == 4'(i))) begin
				wfile_reg[i] <= mulP[31:16];
			end
		end
	end

	// Stack pointer is the top entry
	assign stackPointer = wfile_reg[STACK_IDX];

	// Status word as read, busy reads 0 since reads wait out a divide
	wire [15:0] statusRd = statusFlags_reg | (16'(dv.busy) << POS_BUSY);

	// Read selection; unmapped offsets read zero
	wire [31:0] rdMux = hitCtrl   ? ctrl_reg :
		hitMemIn  ? {16'h0000, memIn_reg} :
		hitMemOut ? {16'h0000, memOut_reg} :
		hitFlags  ? {16'h0000, statusRd} :
		hitWfile  ? {16'h0000, wfile_reg[wIdx]} : 32'h0000_0000;

	// Bus handshake: every transfer gets one wait state, more while dividing
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg    <= 1'b0;
			addr_reg    <= '0;
			isWrite_reg <= 1'b0;
			ready_reg   <= 1'b1;
			resp_reg    <= 1'b0;
		end else begin
			pend_reg  <= accept | (pend_reg & ~doAcc);
			ready_reg <= ~accept & (ready_reg | doAcc);
			resp_reg  <= 1'b0;
			if (accept) begin
				addr_reg    <= haddr;
				isWrite_reg <= hwrite;
			end
		end
	end

	// Read data register, loaded in the execute cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (busRd) begin
			rdata_reg <= rdMux;
		end
	end

	// Control and memory-side words
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg   <= CTRL_RST;
			memIn_reg  <= MEM_RST;
			memOut_reg <= MEM_RST;
		end else begin
			if (ctrlWr) begin
				ctrl_reg <= hwdata;
			end
			if (busWr && hitMemIn) begin
				memIn_reg <= hwdata[15:0];
			end
			// Result to memory replaces a software write in the same word
			if (exeAlu && dstMem) begin
				memOut_reg <= loVal;
			end else if (busWr && hitMemOut) begin
				memOut_reg <= hwdata[15:0];
			end
		end
	end

	// Flags: software write or operation update, never both at once
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			statusFlags_reg <= FLAGS_RST;
		end else if (busWr && hitFlags) begin
			statusFlags_reg <= hwdata[15:0] & FLAGS_WMASK;
		end else begin
			statusFlags_reg <= statusFlags_next;
		end
	end

	assign hreadyout = ready_reg;
	assign hresp     = resp_reg;
	assign hrdata    = rdata_reg;

	// Checks, one clock domain
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	wire [31:0] ssProd  = {{16{aOp[15]}}, aOp} * {{16{bOp[15]}}, bOp};
	wire [31:0] litProd = {16'h0000, aOp} * {27'h0000000, litVal};

	add_word_a: assert property (
		exeAlu && op == ALU_ADD && !byteMd && dstMem |=> memOut_reg == $past(aOp + bOp))
		else $error("word add result wrong");
	sub_borrow_a: assert property (
		exeAlu && isSub && !byteMd
		|=> statusFlags_reg[POS_CARRY] == ($past(aOp) >= $past(bOp)))
		else $error("subtract carry is not the no-borrow sense");
	zero_flag_a: assert property (
		exeAlu && isArith && dstMem && !byteMd
		|=> statusFlags_reg[POS_ZERO] == (memOut_reg == 16'h0000))
		else $error("zero flag disagrees with result");
	byte_neg_a: assert property (
		exeAlu && isArith && byteMd && dstMem
		|=> statusFlags_reg[POS_NEG] == memOut_reg[7]
		&& memOut_reg[15:8] == $past(memOut_reg[15:8]))
		else $error("byte result or negative flag wrong");
	mul_signed_a: assert property (
		exeAlu && op == MUL_SS && !byteMd && !dstMem
		|=> {wfile_reg[$past(hiIdx)], wfile_reg[$past(loIdx)]} == $past(ssProd))
		else $error("signed product wrong");
	mul_lit_a: assert property (
		exeAlu && op == MUL_ULIT && !byteMd && !dstMem
		|=> {wfile_reg[$past(hiIdx)], wfile_reg[$past(loIdx)]} == $past(litProd))
		else $error("literal product wrong");
	div_result_a: assert property (
		dv.done |=> wfile_reg[QUOT_IDX] == $past(dv.quotient)
		&& wfile_reg[REM_IDX] == $past(dv.remainder))
		else $error("divide answer not in entries 0 and 1");
	bus_wait_a: assert property (
		accept |=> !hreadyout ##1 (hreadyout || dv.busy || pend_reg))
		else $error("transfer completed without its wait state");

	cover_sub_c: cover property (exeAlu && isSub);
	cover_byte_mul_c: cover property (exeAlu && op == MUL_UU && byteMd);
	cover_long_div_c: cover property (dv.start && isLong && op == DIV_S ##17 dv.done);
endmodule

// *** common/alu_dp_pkg.sv ***
// Register map, control field layout, flag positions and opcodes
// of the CPU arithmetic datapath.
// Assumes nothing of its surroundings; both design files import it.
package alu_dp_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL              = 8'h00;
	localparam logic [7:0] OFS_MEM_IN            = 8'h04;
	localparam logic [7:0] OFS_MEM_OUT           = 8'h08;
	localparam logic [7:0] OFS_STATUS_FLAGS_WORD = 8'h0c;
	localparam logic [7:0] OFS_WFILE             = 8'h40;
	// Control word fields, low bit of each
	localparam int CTL_OP      = 0;
	localparam int CTL_BYTE    = 4;
	localparam int CTL_SRC_MEM = 5;
	localparam int CTL_DST_MEM = 6;
	localparam int CTL_LONG    = 7;
	localparam int CTL_RA      = 8;
	localparam int CTL_RB      = 12;
	localparam int CTL_RD      = 16;
	localparam int CTL_LIT     = 20;
	// Bit positions in the status flags word
	localparam int POS_CARRY  = 0;
	localparam int POS_ZERO   = 1;
	localparam int POS_RANGE  = 2;
	localparam int POS_NEG    = 3;
	localparam int POS_NIBBLE = 8;
	localparam int POS_BUSY   = 15;
	localparam logic [15:0] FLAGS_WMASK = 16'h010f;
	// Reset values
	localparam logic [15:0] FLAGS_RST = 16'h0000;
	localparam logic [15:0] WFILE_RST = 16'h0000;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [15:0] MEM_RST   = 16'h0000;
	// Fixed working register roles
	localparam logic [3:0] QUOT_IDX  = 4'h0;
	localparam logic [3:0] REM_IDX   = 4'h1;
	localparam logic [3:0] STACK_IDX = 4'hf;
	// Divide iterations, one per divisor bit
	localparam int DIV_STEPS = 16;
	// Operations
	typedef enum logic [3:0] {
		ALU_ADD  = 4'b0000, ALU_SUB  = 4'b0001, ALU_AND  = 4'b0010, ALU_IOR  = 4'b0011,
		ALU_XOR  = 4'b0100, ALU_SHL  = 4'b0101, ALU_LSR  = 4'b0110, ALU_ASR  = 4'b0111,
		MUL_SS   = 4'b1000, MUL_UU   = 4'b1001, MUL_SU   = 4'b1010, MUL_US   = 4'b1011,
		MUL_SLIT = 4'b1100, MUL_ULIT = 4'b1101, DIV_S    = 4'b1110, DIV_U    = 4'b1111
	} op_e;
	// Divider sequencing
	typedef enum logic [1:0] {
		DV_IDLE = 2'b00,
		DV_RUN  = 2'b01,
		DV_FIX  = 2'b10
	} div_state_e;
endpackage

// *** common/div_if.sv ***
// Operand and answer bundle between the datapath and its divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface div_if;
	logic        start;     // One-cycle launch
	logic        isSigned;  // Signed divide
	logic [31:0] dividend;  // Already widened to 32 bits
	logic [15:0] divisor;   // Divisor word
	logic        busy;      // High while iterating and fixing
	logic        done;      // One cycle, answer valid
	logic [15:0] quotient;  // Signed-corrected quotient
	logic [15:0] remainder; // Signed-corrected remainder
	modport ctrl (output start, isSigned, dividend, divisor,
		input busy, done, quotient, remainder);
	modport unit (input start, isSigned, dividend, divisor,
		output busy, done, quotient, remainder);
endinterface

// *** hdl/alu_divider.sv ***
// Iterative restoring divider: 32/16 magnitude division, signs fixed last.
// Assumes start comes only while idle and the dividend is pre-widened.
`timescale 1ns/1ps
module alu_divider
	import alu_dp_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	// Operand and answer bundle
	div_if.unit       dv
);
	localparam logic [3:0] LAST_STEP = 4'(DIV_STEPS - 1);

	div_state_e  state_reg;  // Sequencer
	logic [16:0] rem_reg;    // Partial remainder
	logic [15:0] quo_reg;    // Dividend low bits, becoming quotient
	logic [15:0] magD_reg;   // Divisor magnitude
	logic [3:0]  cnt_reg;    // Iteration count
	logic        negN_reg;   // Dividend was negative
	logic        negD_reg;   // Divisor was negative

	// Magnitudes of the launch operands
	wire        negN = dv.isSigned & dv.dividend[31];
	wire        negD = dv.isSigned & dv.divisor[15];
	wire [31:0] magN = negN ? (~dv.dividend + 32'h1) : dv.dividend;
	wire [15:0] magD = negD ? (~dv.divisor + 16'h1) : dv.divisor;
	// One restoring step
	wire [16:0] shifted = {rem_reg[15:0], quo_reg[15]};
	wire        fits    = shifted >= {1'b0, magD_reg};
	wire [16:0] diff    = shifted - {1'b0, magD_reg};

	// Sequencer: sixteen steps whatever the dividend length
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= DV_IDLE;
			rem_reg   <= 17'h00000;
			quo_reg   <= 16'h0000;
			magD_reg  <= 16'h0000;
			cnt_reg   <= 4'h0;
			negN_reg  <= 1'b0;
			negD_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				DV_IDLE: if (dv.start) begin
					state_reg <= DV_RUN;
					rem_reg   <= {1'b0, magN[31:16]};
					quo_reg   <= magN[15:0];
					magD_reg  <= magD;
					cnt_reg   <= 4'h0;
					negN_reg  <= negN;
					negD_reg  <= negD;
				end
				DV_RUN: begin
					// One quotient bit per cycle
					rem_reg <= fits ? diff : shifted;
					quo_reg <= {quo_reg[14:0], fits};
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == LAST_STEP) begin
						state_reg <= DV_FIX;
					end
				end
				DV_FIX: state_reg <= DV_IDLE;
				// Unused code 2'b11
				default: state_reg <= DV_IDLE;
			endcase
		end
	end

	// Sign correction on the stored magnitudes
	assign dv.busy      = state_reg != DV_IDLE;
	assign dv.done      = state_reg == DV_FIX;
	assign dv.quotient  = (negN_reg ^ negD_reg) ? (~quo_reg + 16'h1) : quo_reg;
	assign dv.remainder = negN_reg ? (~rem_reg[15:0] + 16'h1) : rem_reg[15:0];

	div_cycles_a: assert property (@(posedge mclk) disable iff (!arst_n)
		dv.start && !dv.busy |-> ##17 dv.done)
		else $error("divide did not finish in 17 cycles");
	div_busy_a: assert property (@(posedge mclk) disable iff (!arst_n)
		dv.start && !dv.busy |=> dv.busy[*8] ##1 dv.busy[*8])
		else $error("divider dropped busy early");
endmodule

// *** sim/ahb_master.sv ***
// Stand-in for the core's AHB-Lite master: single word transfers only.
// Assumes tasks are entered just after a rising edge, hready = hreadyout.
// A stalled slave is waited out; only the bench watchdog ends a hang.
`timescale 1ns/1ps
module ahb_master (
	// Clock
	input  wire logic        mclk,
	// Bus requests
	output logic             hsel,
	output logic [7:0]       haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	// Bus answers
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	// Idle bus from time zero
	initial begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
	end
	// Next rising edge with hready high, however many wait states come first
	task automatic wait_ready();
		@(posedge mclk);
		while (hready !== 1'b1) begin
			@(posedge mclk);
		end
	endtask
	// One transfer; released lines show inverted data, not the last value
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= addr;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize  <= 3'b010;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		haddr  <= ~addr;
		hwdata <= wr ? wd : ~wd;
		wait_ready();
		rd = hrdata;
		hwdata <= ~wd;
	endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench of the CPU arithmetic datapath over AHB-Lite.
// Assumes the bus master model above and the package register map.
`timescale 1ns/1ps
module tb;
	import alu_dp_pkg::*;
	logic        mclk = 1'b0;   // 200 MHz core clock
	logic        arst_n = 1'b0; // Held low at start
	logic        hsel, hwrite, hreadyout, hresp;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata;
	logic [15:0] stackPointer;
	int          miscompares = 0; // Mismatches
	int          cmp_count = 0;   // Comparisons
	always #2.5 mclk = ~mclk;
	ahb_master m (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
	cpu_alu_datapath #(.ADDR_W(8)) dut (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.stackPointer(stackPointer));
	// Compare of a design value
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Compare of a cycle count
	task automatic chk_cnt(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			miscompares++;
			$display("wrong value at %0t: %0d cycles, expected %0d", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		m.xfer(1'b1, a, d, r);
	endtask
	task automatic rdv(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		m.xfer(1'b0, a, 32'h0, r);
		chk_val(r, exp);
	endtask
	function automatic logic [7:0] wa(input int i);
		return OFS_WFILE + 8'(4 * i);
	endfunction
	// Control word; md = {long, dst mem, src mem, byte}
	function automatic logic [31:0] ctl(input op_e op, input logic [3:0] md, ra, rb, rd,
		input logic [4:0] lit);
		return {7'h00, lit, rd, rb, ra, md, op};
	endfunction
	// Flags {nibble, neg, range, zero, carry} into the status word
	function automatic logic [31:0] flg(input logic [4:0] f);
		return 32'(f[4]) << POS_NIBBLE | 32'(f[3:0]);
	endfunction
	// Reset values, every register entry, unmapped place, stack pointer
	task automatic t_regs();
		rdv(OFS_STATUS_FLAGS_WORD, 32'h0);
		chk_val(32'(hresp), 32'h0);
		chk_val(32'(stackPointer), 32'h0);
		for (int i = 0; i < 16; i++) wr(wa(i), {16'h0, 4'(i), ~4'(i), 4'(i), 4'ha});
		for (int i = 0; i < 16; i++) rdv(wa(i), {16'h0, 4'(i), ~4'(i), 4'(i), 4'ha});
		chk_val(32'(stackPointer), 32'h0000f0fa);
		wr(8'h10, 32'h1234_5678);
		rdv(8'h10, 32'h0);
	endtask
	// Word and byte ALU table: operands, result, flags
	task automatic t_alu();
		op_e         op [12] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB, ALU_AND, ALU_IOR,
			ALU_XOR, ALU_SHL, ALU_LSR, ALU_ASR, ALU_ADD, ALU_SUB};
		logic [15:0] a [12] = '{16'hffff, 16'h7fff, 16'h0001, 16'h8000, 16'hf0f0, 16'h8000,
			16'h5555, 16'h8001, 16'h8001, 16'h8001, 16'h12ff, 16'h1200};
		logic [15:0] b [12] = '{16'h0001, 16'h0001, 16'h0002, 16'h0001, 16'h0ff0, 16'h0001,
			16'h5555, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
		logic [15:0] r [12] = '{16'h0000, 16'h8000, 16'hffff, 16'h7fff, 16'h00f0, 16'h8001,
			16'h0000, 16'h0002, 16'h4000, 16'hc000, 16'hab00, 16'habff};
		logic [4:0]  f [12] = '{5'h13, 5'h1c, 5'h08, 5'h05, 5'h00, 5'h08, 5'h02, 5'h01,
			5'h01, 5'h09, 5'h13, 5'h08};
		for (int i = 0; i < 12; i++) begin
			wr(wa(2), a[i]);
			wr(wa(3), b[i]);
			wr(wa(4), 16'habcd);
			wr(OFS_STATUS_FLAGS_WORD, 32'h0);
			wr(OFS_CTRL, ctl(op[i], (i > 9) ? 4'h1 : 4'h0, 4'h2, 4'h3, 4'h4, 5'h0));
			rdv(wa(4), r[i]);
			rdv(OFS_STATUS_FLAGS_WORD, flg(f[i]));
		end
	endtask
	// Memory operand in, memory result out, and memory operand into a register
	task automatic t_mem();
		wr(OFS_MEM_IN, 32'h5);
		wr(wa(2), 32'h3);
		wr(wa(4), 32'h0bad);
		wr(OFS_CTRL, ctl(ALU_ADD, 4'h6, 4'h2, 4'h3, 4'h4, 5'h0));
		rdv(OFS_MEM_OUT, 32'h8);
		rdv(wa(4), 32'h0bad);
		wr(OFS_CTRL, ctl(ALU_SUB, 4'h2, 4'h2, 4'h3, 4'h4, 5'h0));
		rdv(wa(4), 32'hfffe);
		// Byte result to memory keeps the upper byte already there
		wr(OFS_MEM_OUT, 32'h5a00);
		wr(OFS_CTRL, ctl(ALU_ADD, 4'h7, 4'h2, 4'h3, 4'h4, 5'h0));
		rdv(OFS_MEM_OUT, 32'h5a08);
		chk_val(32'(hresp), 32'h0);
	endtask
	// Every multiply mode; product low to entry 6, high to entry 7, the one-word unsigned byte product to entry 6 only
	task automatic t_mul();
		op_e         op [7] = '{MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_UU};
		logic [15:0] a [7] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hfffe, 16'hfffe,
			16'h12ff};
		logic [15:0] b [7] = '{16'h2, 16'h2, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h34ff};
		logic [31:0] p [7] = '{32'hfffffffe, 32'h0001fffe, 32'hffff0001, 32'hffff0001,
			32'hffffffc2, 32'h001effc2, 32'h0000fe01};
		for (int i = 0; i < 7; i++) begin
			wr(wa(2), a[i]);
			wr(wa(3), b[i]);
			wr(wa(7), 32'h0);
			wr(OFS_CTRL, ctl(op[i], (i == 6) ? 4'h1 : 4'h0, 4'h2, 4'h3, 4'h6, 5'h1f));
			rdv(wa(6), p[i][15:0]);
			rdv(wa(7), p[i][31:16]);
		end
	endtask
	// Long and short divides, both signs; stall length must match
	task automatic t_div();
		op_e         op [4] = '{DIV_S, DIV_S, DIV_U, DIV_U};
		logic [31:0] dd [4] = '{32'hfffe7960, 32'h5a5aff9c, 32'h5a5affff, 32'h00010000};
		logic [15:0] q [4] = '{16'hc833, 16'hfff2, 16'h2492, 16'h2492};
		logic [15:0] r [4] = '{16'hfffb, 16'hfffe, 16'h0001, 16'h0002};
		int          n [4];
		realtime     t0;
		for (int i = 0; i < 4; i++) begin
			wr(wa(4), dd[i][15:0]);
			wr(wa(5), dd[i][31:16]);
			wr(wa(6), 32'h7);
			wr(OFS_CTRL, ctl(op[i], (i % 3 == 0) ? 4'h8 : 4'h0, 4'h4, 4'h6, 4'h9, 5'h0));
			t0 = $realtime;
			rdv(wa(QUOT_IDX), q[i]);
			n[i] = int'(($realtime - t0) / 5.0);
			rdv(wa(REM_IDX), r[i]);
			chk_cnt(n[i], n[0]);
		end
		// One step per divisor bit, one fix cycle, one bus wait cycle
		chk_cnt(n[0], DIV_STEPS + 2);
	endtask
	// Verdict, the single place the run ends
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog well beyond the fewer than a thousand cycles the tests need
	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		end_sim();
	end
	// Main sequence, with a second reset after the last test
	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_alu();
		t_mem();
		t_mul();
		t_div();
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		chk_val(32'(stackPointer), 32'h0);
		rdv(wa(QUOT_IDX), 32'h0);
		end_sim();
	end
endmodule
